// *** logic/cpl_link_datapath.sv ***
// Cable link data path: serializer, deserializer, line sensing, link control
`timescale 1ns/1ns

// Pin input filter: three flops, a change counts once stages two and three agree
module cpl_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;
  logic [W-1:0] agree;

  assign agree = ~(s2Q ^ s3Q);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1Q <= INIT;
      s2Q <= INIT;
      s3Q <= INIT;
    end else begin
      s1Q <= din;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dout <= INIT;
    end else begin
      dout <= (dout & ~agree) | (s3Q & agree);
    end
  end
endmodule

// Synchronous FIFO with valid and ready on both sides
module cpl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtrQ;
  logic [AW-1:0] rdPtrQ;
  logic [AW:0] countQ;
  logic push;
  logic pop;

  assign inReady = countQ != (AW+1)'(DEPTH);
  assign outValid = countQ != '0;
  assign outData = mem[rdPtrQ];
  assign level = countQ;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtrQ] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wrPtrQ <= '0;
      rdPtrQ <= '0;
      countQ <= '0;
    end else begin
      if (push) begin
        wrPtrQ <= wrPtrQ + 1'b1;
      end
      if (pop) begin
        rdPtrQ <= rdPtrQ + 1'b1;
      end
      if (push && !pop) begin
        countQ <= countQ + 1'b1;
      end else if (pop && !push) begin
        countQ <= countQ - 1'b1;
      end
    end
  end
endmodule

// Notes on behaviour
// - Link words of 2, 4 or 8 bits, chosen by speed, taken on mclk.
// - Latched bits are serialized and data-strobe encoded at S100, S200 or S400.
// - While sending, data drives pair B and strobe drives pair A.
// - During reception both transmitters are off and the receivers are on.
// - Received data comes from pair A, strobe from pair B, decoded to bits.
// - Received bits form 2-, 4- or 8-bit words, retimed, handed to the link.
// - A reference from the PLL is divided down to make the bit timing.
// - A system clock at half the mclk rate goes out to the link; received data is retimed on mclk.
// - Power-down high halts the PLL and every clock derived from it.
// - Isolation select low turns received data and valid into change pulses for a barrier.
// - Comparator outputs on both pairs give the arbitration status.
// - Common-mode on pair A during arbitration selects the next packet speed.
// - Bias sensed on pair B marks an active remote connection.
// - Power status low 2.6 us resets link outputs; after 26 us the clock stops.
module cpl_link_datapath (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Device pins
  input wire logic power_down_pin,
  input wire logic isoSelN,
  input wire logic linkPowerStatus,
  // Link transmit side
  input wire logic [cpl_pkg::DATA_W-1:0] txData,
  input wire logic [cpl_pkg::SPD_W-1:0] txSpeed,
  input wire logic txValid,
  output logic txReady,
  // Link receive side
  output logic [cpl_pkg::DATA_W-1:0] rxData,
  output logic rxValid,
  output logic [cpl_pkg::SPD_W-1:0] rxSpeed,
  output logic sysClkOut,
  // Arbitration logic, same clock
  input wire logic arbRxGrant,
  input wire logic arbActive,
  // Cable line, transmit
  output logic tpbDataOut,
  output logic tpaStrobeOut,
  output logic lineDriveEn,
  output logic lineRecvEn,
  // Cable line, receive and sense
  input wire logic tpaDataIn,
  input wire logic tpbStrobeIn,
  input wire logic [1:0] compA,
  input wire logic [1:0] compB,
  input wire logic [cpl_pkg::SPD_W-1:0] cmSpeedA,
  input wire logic biasDetB,
  // Line status
  output logic [3:0] arbStatus,
  output logic remoteConnected
);
  // Width and bit period per speed
  function automatic logic [3:0] bitsFor(input logic [1:0] spd);
    unique case (spd)
      cpl_pkg::SPD_S100: bitsFor = cpl_pkg::BITS_S100;
      cpl_pkg::SPD_S200: bitsFor = cpl_pkg::BITS_S200;
      default: bitsFor = cpl_pkg::BITS_S400;
    endcase
  endfunction

  function automatic logic [4:0] divFor(input logic [1:0] spd);
    unique case (spd)
      cpl_pkg::SPD_S100: divFor = cpl_pkg::DIV_S100;
      cpl_pkg::SPD_S200: divFor = cpl_pkg::DIV_S200;
      default: divFor = cpl_pkg::DIV_S400;
    endcase
  endfunction

  // Pin filters
  logic pwrDnS;
  logic isoNS;
  logic lpsS;
  logic aDataS;
  logic bStrobeS;
  logic [3:0] compS;
  logic [1:0] cmSpdS;
  logic biasS;

  cpl_sync3 #(.W(3), .INIT(3'h2)) uCtlSync (
    .mclk(mclk),
    .nrst(nrst),
    .din({power_down_pin, isoSelN, linkPowerStatus}),
    .dout({pwrDnS, isoNS, lpsS})
  );

  cpl_sync3 #(.W(9), .INIT(9'h000)) uLineSync (
    .mclk(mclk),
    .nrst(nrst),
    .din({tpaDataIn, tpbStrobeIn, compA, compB, cmSpeedA, biasDetB}),
    .dout({aDataS, bStrobeS, compS, cmSpdS, biasS})
  );

  logic pllRunQ;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pllRunQ <= 1'b0;
    end else begin
      pllRunQ <= !pwrDnS;
    end
  end

  logic [cpl_pkg::LPS_CNT_W-1:0] lpsLowQ;
  logic linkReset;
  logic linkOff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lpsLowQ <= cpl_pkg::LPS_OFF_LIM;
    end else if (lpsS) begin
      lpsLowQ <= '0;
    end else if (lpsLowQ != cpl_pkg::LPS_OFF_LIM) begin
      lpsLowQ <= lpsLowQ + 1'b1;
    end
  end
  // Strictly longer than the limit counts as inactive
  assign linkReset = lpsLowQ > cpl_pkg::LPS_RST_LIM;
  assign linkOff = lpsLowQ == cpl_pkg::LPS_OFF_LIM;

  // System clock out, held low when halted or link disabled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sysClkOut <= 1'b0;
    end else if (pllRunQ && !linkOff) begin
      sysClkOut <= !sysClkOut;
    end else begin
      sysClkOut <= 1'b0;
    end
  end

  // Transmit FIFO; the slow serializer back-pressures the link
  logic [cpl_pkg::DATA_W+cpl_pkg::SPD_W-1:0] fifoOut;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [3:0] fifoLevel;

  cpl_fifo #(.W(cpl_pkg::DATA_W + cpl_pkg::SPD_W), .DEPTH(cpl_pkg::FIFO_DEPTH)) uTxFifo (
    .mclk(mclk),
    .nrst(nrst),
    .inValid(txValid && txReady),
    .inReady(),
    .inData({txSpeed, txData}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut),
    .level(fifoLevel)
  );

  // Take words only while link is up; ready lags a cycle, so keep two free
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txReady <= 1'b0;
    end else begin
      txReady <= !linkReset && (fifoLevel < 4'(cpl_pkg::FIFO_DEPTH - 1));
    end
  end

  // Transmit serializer
  cpl_pkg::cpl_txst_t txStQ;
  logic [7:0] txShQ;
  logic [3:0] txLeftQ;
  logic [4:0] txTimerQ;
  logic [4:0] txDivQ;
  logic [1:0] txSpd;
  logic [3:0] txBits;

  assign txSpd = fifoOut[cpl_pkg::DATA_W +: cpl_pkg::SPD_W];
  assign txBits = bitsFor(txSpd);
  // Reception takes the line, so nothing new starts then
  assign fifoOutReady = (txStQ == cpl_pkg::TX_IDLE) && pllRunQ && !arbRxGrant;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txStQ <= cpl_pkg::TX_IDLE;
      txShQ <= 8'h00;
      txLeftQ <= 4'h0;
      txTimerQ <= 5'h00;
      txDivQ <= cpl_pkg::DIV_S400;
      tpbDataOut <= 1'b0;
      tpaStrobeOut <= 1'b0;
    end else begin
      unique case (txStQ)
        cpl_pkg::TX_IDLE: begin
          if (fifoOutValid && fifoOutReady) begin
            // Left-align so the first bit sits at the top
            txShQ <= fifoOut[7:0] << (4'h8 - txBits);
            txLeftQ <= txBits;
            txDivQ <= divFor(txSpd);
            txTimerQ <= 5'h00;
            txStQ <= cpl_pkg::TX_SHIFT;
          end
        end
        cpl_pkg::TX_SHIFT: begin
          // Bit timing from divided reference; frozen while halted
          if (pllRunQ && txTimerQ != 5'h00) begin
            txTimerQ <= txTimerQ - 1'b1;
          end else if (pllRunQ) begin
            txTimerQ <= txDivQ - 1'b1;
            if (txLeftQ == 4'h0) begin
              txStQ <= cpl_pkg::TX_IDLE;
            end else begin
              // Data on pair B, strobe on pair A
              tpbDataOut <= txShQ[7];
              tpaStrobeOut <= tpaStrobeOut ^ !(txShQ[7] ^ tpbDataOut);
              txShQ <= {txShQ[6:0], 1'b0};
              txLeftQ <= txLeftQ - 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Drivers off, receivers on during reception
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lineDriveEn <= 1'b0;
      lineRecvEn <= 1'b0;
    end else begin
      lineDriveEn <= (txStQ == cpl_pkg::TX_SHIFT) && !arbRxGrant && pllRunQ;
      lineRecvEn <= arbRxGrant && pllRunQ;
    end
  end

  logic [1:0] peerSpdQ;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      peerSpdQ <= cpl_pkg::SPD_S100;
    end else if (arbActive) begin
      peerSpdQ <= cmSpdS;
    end
  end

  // Data-strobe decode; each phase change carries one bit
  logic phasePrevQ;
  logic phase;
  logic newBit;
  logic [7:0] rxShQ;
  logic [3:0] rxCntQ;
  logic [7:0] rxWordQ;
  logic rxDoneQ;

  assign phase = aDataS ^ bStrobeS;
  assign newBit = lineRecvEn && (phase != phasePrevQ);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phasePrevQ <= 1'b0;
    end else begin
      phasePrevQ <= phase;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxShQ <= 8'h00;
      rxCntQ <= 4'h0;
      rxWordQ <= 8'h00;
      rxDoneQ <= 1'b0;
    end else begin
      rxDoneQ <= 1'b0;
      if (!lineRecvEn) begin
        rxCntQ <= 4'h0;
        rxShQ <= 8'h00;
      end else if (newBit) begin
        rxShQ <= {rxShQ[6:0], aDataS};
        if (rxCntQ + 1'b1 == bitsFor(peerSpdQ)) begin
          // Cleared per word so narrow words carry no stale upper bits
          rxWordQ <= {rxShQ[6:0], aDataS};
          rxShQ <= 8'h00;
          rxDoneQ <= 1'b1;
          rxCntQ <= 4'h0;
        end else begin
          rxCntQ <= rxCntQ + 1'b1;
        end
      end
    end
  end

  // Received data and valid to the link held low while link is reset
  logic [8:0] lvlQ;
  logic [8:0] lvlDlyQ;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lvlQ <= 9'h000;
      lvlDlyQ <= 9'h000;
    end else begin
      lvlDlyQ <= lvlQ;
      if (linkReset) begin
        lvlQ <= 9'h000;
      end else begin
        lvlQ <= {rxDoneQ, rxDoneQ ? rxWordQ : lvlQ[7:0]};
      end
    end
  end

  // Level or change-pulse output shaping; costs one cycle of latency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rxValid <= 1'b0;
      rxData <= 8'h00;
    end else if (isoNS) begin
      {rxValid, rxData} <= lvlQ;
    end else begin
      {rxValid, rxData} <= lvlQ ^ lvlDlyQ;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arbStatus <= 4'h0;
      remoteConnected <= 1'b0;
      rxSpeed <= cpl_pkg::SPD_S100;
    end else begin
      arbStatus <= compS;
      remoteConnected <= biasS;
      rxSpeed <= linkReset ? cpl_pkg::SPD_S100 : peerSpdQ;
    end
  end
endmodule

// *** logic/cpl_pkg.sv ***
// Shared constants and types for the cable link data path
package cpl_pkg;
  // Clock rate of mclk in MHz
  localparam int CLK_MHZ = 20;
  // Link power status timing, in ns
  localparam int LPS_RST_NS = 2600;
  localparam int LPS_OFF_NS = 26000;
  // Least times round up to whole cycles
  localparam int LPS_RST_CYC = (LPS_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int LPS_OFF_CYC = (LPS_OFF_NS * CLK_MHZ + 999) / 1000;
  localparam int LPS_CNT_W = 10;
  localparam logic [LPS_CNT_W-1:0] LPS_RST_LIM = LPS_CNT_W'(LPS_RST_CYC);
  localparam logic [LPS_CNT_W-1:0] LPS_OFF_LIM = LPS_CNT_W'(LPS_OFF_CYC);
  // Data path widths
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int SPD_W = 2;
  // Bits per link word at each speed
  localparam logic [3:0] BITS_S100 = 4'h2;
  localparam logic [3:0] BITS_S200 = 4'h4;
  localparam logic [3:0] BITS_S400 = 4'h8;
  // mclk cycles per line bit at each speed, ratio 4:2:1
  localparam logic [4:0] DIV_S100 = 5'h10;
  localparam logic [4:0] DIV_S200 = 5'h08;
  localparam logic [4:0] DIV_S400 = 5'h04;
  // Speed codes
  typedef enum logic [1:0] {
    SPD_S100 = 2'b00,
    SPD_S200 = 2'b01,
    SPD_S400 = 2'b10
  } cpl_speed_t;
  // Transmit sequencer
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } cpl_txst_t;
endpackage

// *** logic/zz_unused.sv ***
// Intentionally empty; all logic lives in the data path file
`timescale 1ns/1ns

// *** sim/cpl_cable_peer.sv ***
// Cable-side peer: decodes the sent stream and sends data-strobe bits
`timescale 1ns/1ns
module cpl_cable_peer (
  // Clock
  input wire logic mclk,
  // Line from the device
  input wire logic tpbDataOut,
  input wire logic tpaStrobeOut,
  input wire logic lineDriveEn,
  // Line into the device
  output logic tpaDataIn,
  output logic tpbStrobeIn
);
  bit got[$];
  bit busy = 0;
  logic prevD = 0, prevS = 0;
  initial {tpaDataIn, tpbStrobeIn} = 2'b00;
  always @(negedge mclk) begin
    // one bit per edge, data on pair B
    if (lineDriveEn === 1'b1 && {tpbDataOut, tpaStrobeOut} !== {prevD, prevS}) begin
      got.push_back(tpbDataOut);
    end
    {prevD, prevS} = {tpbDataOut, tpaStrobeOut};
    // Idle lines wander together, so no bit edge
    if (!busy) {tpaDataIn, tpbStrobeIn} = ~{tpaDataIn, tpbStrobeIn};
  end
  // data on pair A, strobe on pair B
  task automatic send(input logic [7:0] w, input int n);
    busy = 1;
    repeat (6) @(negedge mclk);
    for (int i = n - 1; i >= 0; i--) begin
      if (w[i] === tpaDataIn) tpbStrobeIn = ~tpbStrobeIn;
      tpaDataIn = w[i];
      repeat (8) @(negedge mclk);
    end
    busy = 0;
  endtask
endmodule

// *** sim/cpl_link_datapath_bench.sv ***
// Self-checking bench for the cable link data path
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nTests++; if ((e) !== (g)) begin mismatches++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module cpl_link_datapath_bench;
  logic mclk = 0, nrst = 0, power_down_pin = 0, isoSelN = 1, linkPowerStatus = 1;
  logic [7:0] txData = '0, rxData, w, lastW = '0;
  logic [1:0] txSpeed = '0, rxSpeed, compA = '0, compB = '0, cmSpeedA = '0;
  logic txValid = 0, txReady, rxValid, sysClkOut, arbRxGrant = 0, arbActive = 0;
  logic tpbDataOut, tpaStrobeOut, lineDriveEn, lineRecvEn, tpaDataIn, tpbStrobeIn;
  logic biasDetB = 0, remoteConnected;
  logic [3:0] arbStatus;
  int mismatches = 0, nTests = 0, stalls = 0, k, g;
  bit expQ[$];
  logic [7:0] rxQ[$];
  always #25 mclk = ~mclk;
  cpl_link_datapath uut (.mclk, .nrst, .power_down_pin, .isoSelN, .linkPowerStatus, .txData,
    .txSpeed, .txValid, .txReady, .rxData, .rxValid, .rxSpeed, .sysClkOut, .arbRxGrant,
    .arbActive, .tpbDataOut, .tpaStrobeOut, .lineDriveEn, .lineRecvEn, .tpaDataIn,
    .tpbStrobeIn, .compA, .compB, .cmSpeedA, .biasDetB, .arbStatus, .remoteConnected);
  cpl_cable_peer peer (.mclk, .tpbDataOut, .tpaStrobeOut, .lineDriveEn, .tpaDataIn,
    .tpbStrobeIn);
  always @(negedge mclk) if (rxValid === 1'b1) rxQ.push_back(rxData);
  function automatic int nb(input logic [1:0] s);
    return (s == 2'h0) ? 2 : (s == 2'h1) ? 4 : 8;
  endfunction
  function automatic logic [7:0] mask(input logic [1:0] s);
    return (8'h01 << nb(s)) - 8'h01;
  endfunction
  task automatic waitrdy;
    for (k = 0; k < 100 && txReady !== 1'b1; k++) @(negedge mclk);
  endtask
  task automatic clkchk(input bit run);
    logic a;
    a = sysClkOut;
    @(negedge mclk);
    if (run) `CHK("sysClkRun", 1'b1, a ^ sysClkOut)
    else `CHK("sysClkStop", 1'b0, a | sysClkOut)
  endtask
  // Word held until taken; low bits go out first bit highest
  task automatic putw(input logic [1:0] s, input logic [7:0] d);
    txSpeed = s;
    txData = d;
    txValid = 1;
    for (int i = nb(s) - 1; i >= 0; i--) expQ.push_back(d[i]);
    for (k = 0; k < 2000 && txReady !== 1'b1; k++) @(negedge mclk);
    if (k > 0) stalls++;
    @(negedge mclk);
  endtask
  task automatic getw(input logic [1:0] s, input logic [7:0] d, input logic [7:0] e);
    cmSpeedA = s;
    arbActive = 1;
    repeat (8) @(negedge mclk);
    arbActive = 0;
    arbRxGrant = 1;
    rxQ.delete();
    peer.send(d, nb(s));
    repeat (8) @(negedge mclk);
    arbRxGrant = 0;
    `CHK("rxSpeed", s, rxSpeed)
    `CHK("rxWord", e, rxQ[0])
    if (isoSelN) `CHK("rxCount", 1, rxQ.size())
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    mismatches++;
    results();
  end
  initial begin
    void'($urandom(32'h1C58));
    repeat (6) @(negedge mclk);
    nrst = 1;
    waitrdy();
    clkchk(1);
    $display("test reset done");
    // Corner words, then 18 random back to back so the buffer refuses at least once
    putw(2'h2, 8'h00);
    putw(2'h2, 8'hFF);
    putw(2'h3, 8'hA5);
    for (int i = 0; i < 18; i++) putw(2'($urandom), 8'($urandom));
    txValid = 0;
    for (k = 0; k < 20000 && peer.got.size() < expQ.size(); k++) @(negedge mclk);
    repeat (40) @(negedge mclk);
    `CHK("txBitCount", expQ.size(), peer.got.size())
    foreach (expQ[i]) `CHK("txBit", expQ[i], peer.got[i])
    `CHK("txStalled", 1'b1, stalls > 0)
    `CHK("lineIdle", 1'b0, lineDriveEn)
    $display("test transmit done");
    for (int i = 0; i < 6; i++) begin
      txSpeed = (i < 3) ? 2'(i) : 2'($urandom % 3);
      w = 8'($urandom) & mask(txSpeed);
      getw(txSpeed, w, w);
      lastW = w;
    end
    $display("test receive done");
    isoSelN = 0;
    repeat (8) @(negedge mclk);
    w = 8'($urandom);
    getw(2'h2, w, w ^ lastW);
    isoSelN = 1;
    repeat (8) @(negedge mclk);
    $display("test isolation done");
    for (int i = 0; i < 4; i++) begin
      {compA, compB, biasDetB} = 5'($urandom);
      repeat (10) @(negedge mclk);
      `CHK("arbStatus", {compA, compB}, arbStatus)
      `CHK("remoteConnected", biasDetB, remoteConnected)
    end
    $display("test compare done");
    power_down_pin = 1;
    repeat (10) @(negedge mclk);
    clkchk(0);
    power_down_pin = 0;
    repeat (10) @(negedge mclk);
    clkchk(1);
    $display("test powerdown done");
    linkPowerStatus = 0;
    repeat (70) @(negedge mclk);
    `CHK("txReadyOff", 1'b0, txReady)
    clkchk(1);
    txValid = 1;
    g = peer.got.size();
    repeat (480) @(negedge mclk);
    clkchk(0);
    `CHK("requestIgnored", g, peer.got.size())
    txValid = 0;
    linkPowerStatus = 1;
    waitrdy();
    `CHK("txReadyBack", 1'b1, txReady)
    clkchk(1);
    $display("test linkpower done");
    results();
  end
endmodule
bind cpl_link_datapath cpl_link_chk chk (.mclk, .nrst, .power_down_pin, .isoSelN,
  .linkPowerStatus, .txReady, .rxData, .rxValid, .sysClkOut, .arbRxGrant, .tpbDataOut,
  .tpaStrobeOut, .lineDriveEn, .lineRecvEn, .compA, .compB, .biasDetB, .arbStatus,
  .remoteConnected);

// *** sim/cpl_link_datapath_chk.sv ***
// Port-level properties of the cable link data path
`timescale 1ns/1ns
module cpl_link_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Pins and link side
  input wire logic power_down_pin,
  input wire logic isoSelN,
  input wire logic linkPowerStatus,
  input wire logic txReady,
  input wire logic [cpl_pkg::DATA_W-1:0] rxData,
  input wire logic rxValid,
  input wire logic sysClkOut,
  input wire logic arbRxGrant,
  // Line side
  input wire logic tpbDataOut,
  input wire logic tpaStrobeOut,
  input wire logic lineDriveEn,
  input wire logic lineRecvEn,
  input wire logic [1:0] compA,
  input wire logic [1:0] compB,
  input wire logic biasDetB,
  input wire logic [3:0] arbStatus,
  input wire logic remoteConnected
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic [9:0] lowCnt;
  // Saturates so a long sleep never wraps
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lowCnt <= '0;
    end else if (linkPowerStatus) begin
      lowCnt <= '0;
    end else if (lowCnt != 10'h3FF) begin
      lowCnt <= lowCnt + 10'h001;
    end
  end
  a_drive_recv_excl: assert property (
    !(lineDriveEn && lineRecvEn))
    else $error("line driven while receiving");
  a_recv_no_grant: assert property (
    !arbRxGrant |=> !lineRecvEn)
    else $error("receivers on without grant");
  a_recv_rise: assert property (
    $rose(lineRecvEn) |-> $past(arbRxGrant))
    else $error("receivers rose without grant");
  a_rx_one_pulse: assert property (
    rxValid && isoSelN && $past(isoSelN, 8) |=> !rxValid)
    else $error("receive valid longer than a cycle");
  a_ds_one_edge: assert property (
    lineDriveEn && $past(lineDriveEn) |-> !($changed(tpbDataOut) && $changed(tpaStrobeOut)))
    else $error("data and strobe changed together");
  a_pd_quiet: assert property (
    power_down_pin [*8] |-> !sysClkOut && !lineDriveEn && !lineRecvEn)
    else $error("activity during power down");
  a_lps_reset: assert property (
    lowCnt >= 10'(cpl_pkg::LPS_RST_CYC + 8) |-> !txReady && !rxValid && rxData == '0)
    else $error("link outputs active while link off");
  a_lps_clk_stop: assert property (
    lowCnt >= 10'(cpl_pkg::LPS_OFF_CYC + 8) |-> !sysClkOut)
    else $error("system clock runs while link disabled");
  a_arb_status: assert property (
    $stable({compA, compB}) [*8] |-> arbStatus == {compA, compB})
    else $error("arbitration status differs from comparators");
  a_remote_bias: assert property (
    $stable(biasDetB) [*8] |-> remoteConnected == biasDetB)
    else $error("remote connection differs from bias sense");
endmodule
